// ---- logic/converter_trim_and_swap_regs.sv ----
// Purpose: Trim and swap timing register bank with swap sequencer
// Assumes: Converter clock is clk; host obeys the write restrictions
// Notes:   One wait state on every Wishbone access, reads included
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ns
module converter_trim_and_swap_regs (
  input  logic                    clk,
  input  logic                    rst,
  input  trim_swap_pkg::wb_req_type wb_req,
  output logic                    wb_ack,
  output logic [31:0]             wb_dat_o,
  input  trim_swap_pkg::fuse_type fuse,
  input  logic                    swap_start,
  input  logic                    swap_target,
  output trim_swap_pkg::trim_type trim,
  output trim_swap_pkg::swap_type swap_out
);
  import trim_swap_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [NUM_REGS-1:0][7:0] reg_value;
  logic [NUM_REGS-1:0][7:0] reg_reset;
  logic [NUM_REGS-1:0]      reg_write;
  logic [9:0]               index;
  logic                     request;
  logic                     write_now;
  logic                     next_ack;
  logic [31:0]              next_dat;
  swap_state_type           state;
  swap_state_type           next_state;
  logic [6:0]               overlap_len;
  logic [4:0]               steer_len;
  logic                     accept;
  logic                     ovl_busy;
  logic                     ovl_done;
  logic                     steer_busy;
  logic                     steer_done;
  logic                     pending;
  logic                     next_pending;
  logic                     select;
  logic                     next_select;
  logic                     swap_busy;
  logic [6:0]               dual_cnt;
  logic [6:0]               len_cap;

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  // Word index from byte address
  assign index     = wb_req.adr[11:2];
  assign request   = wb_req.cyc & wb_req.stb;
  // Write lands on the edge where the master sees ack
  assign write_now = request & wb_req.we & wb_ack & wb_req.sel[0];

  // Read mux; unmapped words answer zero
  always_comb begin
    next_ack = request & ~wb_ack;
    next_dat = wb_dat_o;
    if (next_ack) begin
      next_dat = 32'h0000_0000;
      for (int i = 0; i < NUM_REGS; i++) begin
        if (index == REG_INDEX[i]) begin
          next_dat = {24'h00_0000, reg_value[i]};
        end
      end
      if (index == STATUS_INDEX) begin
        next_dat = {29'h0000_0000, select, state == SWAP_OVERLAP, swap_busy};
      end
    end
  end

  // Ack drops after one cycle so a held request is not answered twice
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack   <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack   <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  // Trims reload from fuse, swap and dither from constants; the reference
  // reserved nibble resets to zero whatever the fuse word holds
  assign reg_reset = {RST_DITHER, RST_STEER, RST_OVERLAP,
                      fuse.term, 4'h0, fuse.ref_adj[REF_MSB:0], fuse.gain};

  // Decode per slot; only byte lane 0 carries data
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      reg_write[i] = write_now && (index == REG_INDEX[i]);
    end
  end

  // Full byte kept, so reserved bits read back as written
  for (genvar g = 0; g < NUM_REGS; g++) begin : gen_reg
    config_reg #(
      .WIDTH (8)
    ) u_reg (
      .clk         (clk),
      .rst         (rst),
      .reset_value (reg_reset[g]),
      .write       (reg_write[g]),
      .write_data  (wb_req.dat[7:0]),
      .value       (reg_value[g])
    );
  end

  // ----------------------------------------
  // Analog trim outputs
  // ----------------------------------------
  // Gain trim drives all cores as one
  assign trim.gain    = reg_value[SLOT_GAIN];
  assign trim.ref_adj = reg_value[SLOT_REF][REF_MSB:0];
  assign trim.term    = reg_value[SLOT_TERM+3:SLOT_TERM];
  // Dither controls straight off the register
  assign trim.dither_on               = reg_value[SLOT_DITHER][DITHER_ON_BIT];
  assign trim.dither_amplitude_select = reg_value[SLOT_DITHER][DITHER_AMP_BIT];
  assign trim.dither_rounding_select  = reg_value[SLOT_DITHER][DITHER_ROUND_BIT];

  // ----------------------------------------
  // Swap timing
  // ----------------------------------------
  // Overlap of 4 + 2N cycles; widened to avoid wrap at N = 31
  assign overlap_len = OVERLAP_BASE + {1'b0, reg_value[SLOT_OVERLAP][FIELD_MSB:0], 1'b0};
  assign steer_len   = reg_value[SLOT_STEER][FIELD_MSB:0];
  // A start during a swap is dropped; lengths latch at start,
  // so a late write cannot tear a running swap
  assign accept      = swap_start & ~swap_busy;
  assign swap_busy   = (state == SWAP_OVERLAP) | steer_busy;

  cycle_timer #(
    .WIDTH (7)
  ) u_overlap (
    .clk    (clk),
    .rst    (rst),
    .start  (accept),
    .length (overlap_len),
    .busy   (ovl_busy),
    .done   (ovl_done)
  );

  cycle_timer #(
    .WIDTH (5)
  ) u_steer (
    .clk    (clk),
    .rst    (rst),
    .start  (accept),
    .length (steer_len),
    .busy   (steer_busy),
    .done   (steer_done)
  );

  // Both cores sample together while in overlap
  always_comb begin
    next_state = state;
    case (state)
      SWAP_IDLE: begin
        if (accept) begin
          next_state = SWAP_OVERLAP;
        end
      end
      SWAP_OVERLAP: begin
        if (ovl_done) begin
          next_state = SWAP_IDLE;
        end
      end
      default: begin
        next_state = SWAP_IDLE;
      end
    endcase
  end

  // Select moves only after the steer delay during a swap
  always_comb begin
    next_pending = pending;
    next_select  = select;
    if (accept) begin
      next_pending = swap_target;
      if (steer_len == 5'h00) begin
        next_select = swap_target;
      end
    end else if (steer_done) begin
      next_select = pending;
    end else if (!swap_busy) begin
      next_select = swap_target;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state   <= SWAP_IDLE;
      pending <= 1'b0;
      select  <= 1'b0;
    end else begin
      state   <= next_state;
      pending <= next_pending;
      select  <= next_select;
    end
  end

  assign swap_out.busy         = swap_busy;
  assign swap_out.dual_sample  = (state == SWAP_OVERLAP);
  assign swap_out.steer_select = select;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Counts overlap cycles for the length check
  always_ff @(posedge clk) begin
    if (rst) begin
      dual_cnt <= 7'h00;
      len_cap  <= 7'h00;
    end else begin
      dual_cnt <= swap_out.dual_sample ? dual_cnt + 7'h01 : 7'h00;
      len_cap  <= accept ? overlap_len : len_cap;
    end
  end

  a_ack_one_wait: assert property (@(posedge clk) disable iff (rst)
    request && !wb_ack |=> wb_ack)
    else $error("ack missing one cycle after request");

  a_ack_single: assert property (@(posedge clk) disable iff (rst)
    wb_ack |=> !wb_ack)
    else $error("ack held beyond one cycle");

  a_fuse_reload: assert property (@(posedge clk)
    $past(rst) |-> trim.gain == $past(fuse.gain) && trim.term == $past(fuse.term))
    else $error("trim did not reload fuse value");

  a_overlap_reset: assert property (@(posedge clk)
    $past(rst) |-> reg_value[SLOT_OVERLAP] == 8'h08)
    else $error("overlap reset value wrong");

  a_steer_reset: assert property (@(posedge clk)
    $past(rst) |-> reg_value[SLOT_STEER] == 8'h07)
    else $error("steer reset value wrong");

  a_gain_write: assert property (@(posedge clk) disable iff (rst)
    reg_write[SLOT_GAIN] |=> trim.gain == $past(wb_req.dat[7:0]))
    else $error("gain write lost");

  a_ref_write: assert property (@(posedge clk) disable iff (rst)
    reg_write[SLOT_REF] |=> trim.ref_adj == $past(wb_req.dat[3:0])
      && reg_value[SLOT_REF][7:4] == $past(wb_req.dat[7:4]))
    else $error("reference write lost");

  a_term_write: assert property (@(posedge clk) disable iff (rst)
    reg_write[SLOT_TERM+2] |=> trim.term[2] == $past(wb_req.dat[7:0])
      && $stable(trim.term[1]))
    else $error("termination write crossed channels");

  a_dither_write: assert property (@(posedge clk) disable iff (rst)
    reg_write[SLOT_DITHER] |=> trim.dither_on == $past(wb_req.dat[0])
      && trim.dither_amplitude_select == $past(wb_req.dat[1]))
    else $error("dither controls wrong");

  a_overlap_len: assert property (@(posedge clk) disable iff (rst)
    $fell(swap_out.dual_sample) |-> dual_cnt == len_cap)
    else $error("overlap length not 4 + 2N");

  a_overlap_start: assert property (@(posedge clk) disable iff (rst)
    accept |=> swap_out.dual_sample [*4])
    else $error("overlap shorter than four cycles");

  a_steer_hold: assert property (@(posedge clk) disable iff (rst)
    steer_busy && !steer_done |=> $stable(select))
    else $error("select moved before steer delay");

  a_steer_apply: assert property (@(posedge clk) disable iff (rst)
    steer_done && !accept |=> select == $past(pending))
    else $error("select not applied after steer delay");

  a_ref_reset: assert property (@(posedge clk)
    $past(rst) |-> reg_value[SLOT_REF][7:4] == 4'h0
      && trim.ref_adj == $past(fuse.ref_adj[3:0]))
    else $error("reference reset value wrong");

  a_dither_reset: assert property (@(posedge clk)
    $past(rst) |-> reg_value[SLOT_DITHER] == 8'h00)
    else $error("dither reset value wrong");

  a_lane_masked: assert property (@(posedge clk) disable iff (rst)
    request && wb_req.we && wb_ack && !wb_req.sel[0] |=> $stable(reg_value))
    else $error("write with lane zero disabled was stored");

  a_read_gain: assert property (@(posedge clk) disable iff (rst)
    request && !wb_req.we && !wb_ack && index == REG_INDEX[SLOT_GAIN]
      |=> wb_dat_o == {24'h00_0000, $past(reg_value[SLOT_GAIN])})
    else $error("gain read data wrong");

  a_busy_start: assert property (@(posedge clk) disable iff (rst)
    accept |=> swap_out.busy [*4])
    else $error("busy dropped inside the overlap");

  a_steer_zero: assert property (@(posedge clk) disable iff (rst)
    accept && steer_len == 5'h00 |=> select == $past(swap_target))
    else $error("select not moved at once for zero delay");

endmodule

// ---- logic/trim_swap_pkg.sv ----
// Purpose: Constants and types for the converter trim and swap bank
// Assumes: Registers reached over classic Wishbone, 32-bit data
// Notes:   Printed offsets are word indexes; byte address is index * 4
//
// What this block does
// - Eight-bit read/write gain trim shared by all converter cores.
// - Four-bit reference trim in low bits; upper four bits reserved.
// - Trim registers load their fuse value at reset; software may overwrite.
// - Four independent eight-bit termination trims, one per input channel.
// - Swap overlap lasts four plus twice the overlap setting clock cycles.
// - Overlap field bits 4:0, range 0 to 31, resets to 8.
// - Steering select change is delayed by the steer setting during swaps.
// - Steer field bits 4:0, range 0 to 31, resets to 7.
// - Dither register bit 0 enables dither, bit 1 picks large amplitude.
package trim_swap_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int NUM_REGS     = 9;
  localparam int SLOT_GAIN    = 0;
  localparam int SLOT_REF     = 1;
  localparam int SLOT_TERM    = 2;
  localparam int SLOT_OVERLAP = 6;
  localparam int SLOT_STEER   = 7;
  localparam int SLOT_DITHER  = 8;
  localparam logic [NUM_REGS-1:0][9:0] REG_INDEX = {
    10'h09D, 10'h09B, 10'h09A, 10'h081, 10'h080,
    10'h07F, 10'h07E, 10'h07C, 10'h07A};
  localparam logic [9:0]  STATUS_INDEX = 10'h09F;

  // ----------------------------------------
  // Reset values and fields
  // ----------------------------------------
  localparam logic [7:0]  RST_OVERLAP      = 8'h08;
  localparam logic [7:0]  RST_STEER        = 8'h07;
  localparam logic [7:0]  RST_DITHER       = 8'h00;
  localparam int          FIELD_MSB        = 4;
  localparam int          REF_MSB          = 3;
  localparam int          DITHER_ON_BIT    = 0;
  localparam int          DITHER_AMP_BIT   = 1;
  localparam int          DITHER_ROUND_BIT = 2;
  localparam logic [6:0]  OVERLAP_BASE     = 7'h04;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } wb_req_type;

  typedef struct packed {
    logic [3:0][7:0] term;
    logic [7:0]      ref_adj;
    logic [7:0]      gain;
  } fuse_type;

  typedef struct packed {
    logic [3:0][7:0] term;
    logic [3:0]      ref_adj;
    logic [7:0]      gain;
    logic            dither_on;
    logic            dither_amplitude_select;
    logic            dither_rounding_select;
  } trim_type;

  typedef struct packed {
    logic busy;
    logic dual_sample;
    logic steer_select;
  } swap_type;

  typedef enum logic [1:0] {
    SWAP_IDLE    = 2'b01,
    SWAP_OVERLAP = 2'b10
  } swap_state_type;

endpackage

// ---- logic/config_reg.sv ----
// Purpose: One software register that reloads a given value at reset
// Assumes: Synchronous active high reset
// Notes:   Reset value may be a live fuse input, sampled on the clock
`timescale 1ns/1ns
module config_reg #(
  parameter int WIDTH = 8
) (
  input  logic             clk,
  input  logic             rst,
  input  logic [WIDTH-1:0] reset_value,
  input  logic             write,
  input  logic [WIDTH-1:0] write_data,
  output logic [WIDTH-1:0] value
);

  logic [WIDTH-1:0] next_value;

  // Full width stored, reserved bits included
  always_comb begin
    next_value = value;
    if (write) begin
      next_value = write_data;
    end
  end

  // Sync reset, so taking the fuse port here is a clocked capture
  always_ff @(posedge clk) begin
    if (rst) begin
      value <= reset_value;
    end else begin
      value <= next_value;
    end
  end

endmodule

// ---- logic/cycle_timer.sv ----
// Purpose: Down counter that stays busy for a given number of cycles
// Assumes: Length is latched at start; later changes do not disturb it
// Notes:   Zero length gives done in the start cycle and no busy
`timescale 1ns/1ns
module cycle_timer #(
  parameter int WIDTH = 7
) (
  input  logic             clk,
  input  logic             rst,
  input  logic             start,
  input  logic [WIDTH-1:0] length,
  output logic             busy,
  output logic             done
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  // Busy while counting, done on the last busy cycle
  assign busy = (count != '0);
  assign done = (busy && count == WIDTH'(1)) || (start && length == '0);

  always_comb begin
    next_count = count;
    if (start) begin
      next_count = length;
    end else if (busy) begin
      next_count = count - WIDTH'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule

// ---- tb/converter_trim_and_swap_regs_tb_top.sv ----
// Purpose: Self-checking bench for the trim and swap register bank
// Assumes: One wait state per Wishbone access; swap timing counted from accept
// Notes:   Bench model keeps register images in an array; host keeps reserved
//          bits at their reset value
`timescale 1ns/1ns
module converter_trim_and_swap_regs_tb_top;
  import trim_swap_pkg::*;

  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  logic        clk;
  logic        rst;
  wb_req_type  wb_req;
  logic        wb_ack;
  logic [31:0] wb_dat_o;
  fuse_type    fuse;
  logic        swap_start;
  logic        swap_target;
  trim_type    trim;
  swap_type    swap_out;
  int          bad_count;
  int          check_count;
  logic [31:0] seed;
  logic [7:0]  mem [NUM_REGS];
  logic        sel_model;
  logic [7:0]  field_mask [NUM_REGS] = '{8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                         8'h1F, 8'h1F, 8'h07};

  converter_trim_and_swap_regs dut (
    .clk         (clk),
    .rst         (rst),
    .wb_req      (wb_req),
    .wb_ack      (wb_ack),
    .wb_dat_o    (wb_dat_o),
    .fuse        (fuse),
    .swap_start  (swap_start),
    .swap_target (swap_target),
    .trim        (trim),
    .swap_out    (swap_out)
  );

  // Free running 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Fresh fuse image so reset loading is seen with varied data
  function fuse_type rand_fuse();
    fuse_type    f;
    logic [31:0] r;
    r = next_rand();
    f.gain = r[7:0];
    f.ref_adj = r[15:8];
    f.term[0] = r[23:16];
    f.term[1] = r[31:24];
    r = next_rand();
    f.term[2] = r[7:0];
    f.term[3] = r[15:8];
    return f;
  endfunction

  task wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single Wishbone cycle; held until ack is sampled high
  task bus(input logic we, input logic [9:0] idx, input logic [7:0] wd, input logic s0,
           output logic [31:0] rd);
    int i;
    rd = 32'h0;
    @(posedge clk);
    wb_req <= {1'b1, 1'b1, we, {3'b000, s0}, {idx, 2'b00}, {24'h000000, wd}};
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wb_ack === 1'b1) begin
        break;
      end
    end
    if (i == 20) begin
      bad_count++;
      wrap_up();
    end else begin
      rd = wb_dat_o;
      wb_req <= '0;
    end
  endtask

  // Model image after reset: fuse for trims, fixed values for the rest
  task reset_model();
    mem[SLOT_GAIN] = fuse.gain;
    mem[SLOT_REF] = {4'h0, fuse.ref_adj[3:0]};
    for (int k = 0; k < 4; k++) begin
      mem[SLOT_TERM + k] = fuse.term[k];
    end
    mem[SLOT_OVERLAP] = RST_OVERLAP;
    mem[SLOT_STEER] = RST_STEER;
    mem[SLOT_DITHER] = RST_DITHER;
    sel_model = 1'b0;
  endtask

  // Read back every register and compare the trim outputs with the model
  task check_regs();
    logic [31:0] rd;
    for (int k = 0; k < NUM_REGS; k++) begin
      bus(1'b0, REG_INDEX[k], 8'h00, 1'b1, rd);
      check(rd, {24'h000000, mem[k]});
    end
    bus(1'b0, 10'h07B, 8'h00, 1'b1, rd);
    check(rd, 32'h0);
    bus(1'b0, STATUS_INDEX, 8'h00, 1'b1, rd);
    check(rd, {29'h0, sel_model, 2'b00});
    check({24'h0, trim.gain}, {24'h0, mem[SLOT_GAIN]});
    check({28'h0, trim.ref_adj}, {28'h0, mem[SLOT_REF][3:0]});
    for (int k = 0; k < 4; k++) begin
      check({24'h0, trim.term[k]}, {24'h0, mem[SLOT_TERM + k]});
    end
    check({29'h0, trim.dither_rounding_select, trim.dither_amplitude_select,
           trim.dither_on}, {29'h0, mem[SLOT_DITHER][2:0]});
  endtask

  // One background swap; a second request mid-swap must be ignored
  task run_swap(input logic [4:0] n, input logic [4:0] d);
    logic [31:0] rd;
    logic        old;
    logic        tgt;
    // Lengths only change while idle, as a calibration-off host would
    bus(1'b1, REG_INDEX[SLOT_OVERLAP], {3'b000, n}, 1'b1, rd);
    mem[SLOT_OVERLAP] = {3'b000, n};
    bus(1'b1, REG_INDEX[SLOT_STEER], {3'b000, d}, 1'b1, rd);
    mem[SLOT_STEER] = {3'b000, d};
    old = sel_model;
    tgt = ~old;
    @(posedge clk);
    swap_start <= 1'b1;
    swap_target <= tgt;
    for (int i = 1; i <= 72; i++) begin
      @(posedge clk);
      swap_start <= (i == 3);
      check({31'h0, swap_out.dual_sample}, {31'h0, (i >= 2 && i <= 5 + 2 * n)});
      check({31'h0, swap_out.steer_select}, {31'h0, (i >= d + 2) ? tgt : old});
      check({31'h0, swap_out.busy}, {31'h0, (i >= 2 && (i <= 5 + 2 * n || i <= d + 1))});
    end
    sel_model = tgt;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] rd;
    logic [7:0]  v;
    seed = 32'h41068A13;
    bad_count = 0;
    check_count = 0;
    rst = 1'b1;
    wb_req = '0;
    swap_start = 1'b0;
    swap_target = 1'b0;
    fuse = rand_fuse();
    sel_model = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    reset_model();
    check_regs();
    // Enabled write stored, then a byte-disabled one must be dropped
    for (int k = 0; k < NUM_REGS; k++) begin
      rd = next_rand();
      v = rd[7:0] & field_mask[k];
      bus(1'b1, REG_INDEX[k], v, 1'b1, rd);
      mem[k] = v;
      v = ~v & field_mask[k];
      bus(1'b1, REG_INDEX[k], v, 1'b0, rd);
    end
    check_regs();
    run_swap(5'd0, 5'd0);
    run_swap(5'd7, 5'd2);
    run_swap(5'd31, 5'd31);
    rd = next_rand();
    run_swap(rd[4:0], rd[7:3]);
    check_regs();
    // Second reset in mid-run reloads a new fuse image
    @(posedge clk);
    fuse <= rand_fuse();
    swap_target <= 1'b0;
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    reset_model();
    check_regs();
    wrap_up();
  end

  // Cuts a hang short well inside the cycle budget
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    wrap_up();
  end

endmodule
